// ### hdl/string_mul_defs.vh
// Contract
// - String element copy moves one byte or word from source to destination index.
// - After each copied element both index registers point at the next element.
// - With repeat prefix the element copy repeats, giving a block transfer.
// - String element copy leaves every flag exactly as before.
// - Byte multiply: source times low accumulator byte, 16-bit product into accumulator word.
// - Word multiply: source times accumulator word, upper word to data register, lower to accumulator.
// - Both multiply operands and the product are unsigned, no sign extension.
// - Carry is 0 when product upper half is zero, else 1; overflow equals carry.
// - Multiply leaves auxiliary, parity, sign, zero undefined; direction, interrupt, trap unchanged.
`ifndef STRING_MUL_DEFS_VH
`define STRING_MUL_DEFS_VH
// Flag word bit positions
`define FLG_CARRY 0
`define FLG_PARITY 2
`define FLG_AUX 4
`define FLG_ZERO 6
`define FLG_SIGN 7
`define FLG_TRAP 8
`define FLG_INTR 9
`define FLG_DIR 10
`define FLG_OVF 11
// Index steps
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
// Reset values
`define RST_WORD 16'h0000
`define RST_CNT 16'h0000
`endif

// ### hdl/elem_buffer.v
`timescale 1ns/10ps
// ====================================================
// Two-entry buffer between memory read and write sides
module elem_buffer #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem0_q;
  reg [WIDTH-1:0] mem1_q;
  reg [1:0] count_q;
  wire push;
  wire pop;
  assign inReady = (count_q != 2'd2);
  assign outValid = (count_q != 2'd0);
  assign outData = mem0_q;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always @(posedge ref_clk) begin
    if (rst) begin
      count_q <= 2'd0;
      mem0_q <= {WIDTH{1'b0}};
      mem1_q <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      if (pop) begin
        mem0_q <= (count_q == 2'd2) ? mem1_q : inData;
      end else if (push && count_q == 2'd0) begin
        mem0_q <= inData;
      end
      if (push && ((count_q == 2'd1 && !pop) || (count_q == 2'd2))) begin
        mem1_q <= inData;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### hdl/string_mul_unit.v
`timescale 1ns/10ps
`include "string_mul_defs.vh"
// ====================================================
// String element copy and unsigned multiply datapath
module string_mul_unit #(
  parameter WIDTH = 16
) (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  // Command from decoder, busy status back to it
  input wire startCopy,
  input wire startMul,
  input wire wordOp,
  input wire repeatPrefix,
  input wire [WIDTH-1:0] countIn,
  input wire [WIDTH-1:0] srcIndexIn,
  input wire [WIDTH-1:0] dstIndexIn,
  input wire [WIDTH-1:0] accumIn,
  input wire [WIDTH-1:0] mulSrc,
  input wire [WIDTH-1:0] flagsIn,
  output reg busy,
  // Results to register file
  output reg done,
  output reg [WIDTH-1:0] srcIndexOut,
  output reg [WIDTH-1:0] dstIndexOut,
  output reg [WIDTH-1:0] countOut,
  output reg [WIDTH-1:0] accumOut,
  output reg [WIDTH-1:0] dataOut,
  output reg dataWrite,
  output reg [WIDTH-1:0] flagsOut,
  // Memory read port
  output reg rdReq,
  output reg [WIDTH-1:0] rdAddr,
  input wire rdValid,
  input wire [WIDTH-1:0] rdData,
  // Memory write port
  output reg wrReq,
  output reg [WIDTH-1:0] wrAddr,
  output reg [WIDTH-1:0] wrData,
  output reg wrWord,
  input wire wrAck
);
  localparam IDLE = 2'd0;
  localparam COPY = 2'd1;
  localparam FINISH = 2'd2;

  reg [1:0] state_q;
  reg word_q;
  reg dir_q;
  reg [WIDTH-1:0] rdLeft_q;
  reg [WIDTH-1:0] wrLeft_q;
  reg rdWait_q;
  wire bufInReady;
  wire bufOutValid;
  wire [WIDTH-1:0] bufOutData;
  wire [WIDTH-1:0] step;
  wire [2*WIDTH-1:0] product;
  wire [WIDTH-1:0] bytesProduct;
  wire upperNonZero;
  wire wrFree;
  wire drain;

  // ====================================================
  // Index step and unsigned product
  assign step = word_q ? `STEP_WORD : `STEP_BYTE;
  assign product = {{WIDTH{1'b0}}, accumIn} * {{WIDTH{1'b0}}, mulSrc};
  assign bytesProduct = {8'h00, accumIn[7:0]} * {8'h00, mulSrc[7:0]};
  assign upperNonZero = wordOp ? (product[2*WIDTH-1:WIDTH] != `RST_WORD)
                               : (bytesProduct[15:8] != 8'h00);
  assign wrFree = !wrReq || wrAck;
  assign drain = bufOutValid && wrFree && (wrLeft_q != `RST_CNT);

  // ====================================================
  // Element buffer
  elem_buffer #(.WIDTH(WIDTH)) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .inValid(rdValid && rdWait_q),
    .inReady(bufInReady),
    .inData(rdData),
    .outValid(bufOutValid),
    .outReady(drain),
    .outData(bufOutData)
  );

  // ====================================================
  // Control
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= IDLE;
      word_q <= 1'b0;
      dir_q <= 1'b0;
      rdLeft_q <= `RST_CNT;
      wrLeft_q <= `RST_CNT;
      rdWait_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      srcIndexOut <= `RST_WORD;
      dstIndexOut <= `RST_WORD;
      countOut <= `RST_CNT;
      accumOut <= `RST_WORD;
      dataOut <= `RST_WORD;
      dataWrite <= 1'b0;
      flagsOut <= `RST_WORD;
      rdReq <= 1'b0;
      rdAddr <= `RST_WORD;
      wrReq <= 1'b0;
      wrAddr <= `RST_WORD;
      wrData <= `RST_WORD;
      wrWord <= 1'b0;
    end else if (clkEn) begin
      done <= 1'b0;
      dataWrite <= 1'b0;
      if (wrAck) begin
        wrReq <= 1'b0;
      end
      case (state_q)
        IDLE: begin
          if (startMul) begin
            flagsOut <= flagsIn;
            flagsOut[`FLG_CARRY] <= upperNonZero;
            flagsOut[`FLG_OVF] <= upperNonZero;
            if (wordOp) begin
              accumOut <= product[WIDTH-1:0];
              dataOut <= product[2*WIDTH-1:WIDTH];
              dataWrite <= 1'b1;
            end else begin
              accumOut <= bytesProduct;
            end
            done <= 1'b1;
          end else if (startCopy) begin
            flagsOut <= flagsIn;
            word_q <= wordOp;
            dir_q <= flagsIn[`FLG_DIR];
            srcIndexOut <= srcIndexIn;
            dstIndexOut <= dstIndexIn;
            rdAddr <= srcIndexIn;
            rdLeft_q <= repeatPrefix ? countIn : 16'h0001;
            wrLeft_q <= repeatPrefix ? countIn : 16'h0001;
            countOut <= repeatPrefix ? countIn : `RST_CNT;
            busy <= 1'b1;
            state_q <= COPY;
          end
        end
        COPY: begin
          if (rdWait_q && rdValid) begin
            rdWait_q <= 1'b0;
          end
          // Issue next read only when buffer can absorb it
          if (!rdReq && !rdWait_q && rdLeft_q != `RST_CNT && bufInReady) begin
            rdReq <= 1'b1;
          end else if (rdReq) begin
            rdReq <= 1'b0;
            rdWait_q <= 1'b1;
            rdLeft_q <= rdLeft_q - 16'h0001;
            rdAddr <= dir_q ? rdAddr - step : rdAddr + step;
            srcIndexOut <= dir_q ? srcIndexOut - step : srcIndexOut + step;
          end
          if (drain) begin
            wrReq <= 1'b1;
            wrAddr <= dstIndexOut;
            wrData <= word_q ? bufOutData : {8'h00, bufOutData[7:0]};
            wrWord <= word_q;
            wrLeft_q <= wrLeft_q - 16'h0001;
            dstIndexOut <= dir_q ? dstIndexOut - step : dstIndexOut + step;
            if (countOut != `RST_CNT) begin
              countOut <= countOut - 16'h0001;
            end
          end
          if (wrLeft_q == `RST_CNT && rdLeft_q == `RST_CNT) begin
            state_q <= FINISH;
          end
        end
        FINISH: begin
          if (!wrReq || wrAck) begin
            busy <= 1'b0;
            done <= 1'b1;
            state_q <= IDLE;
          end
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end
endmodule

// ### tb/string_mul_unit_properties.sv
`timescale 1ns/10ps
// ==========
// Checker on the datapath ports
module string_mul_unit_properties (
  // Clock and control
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire startCopy,
  input wire startMul,
  input wire wordOp,
  input wire busy,
  input wire done,
  // Operands and results
  input wire [15:0] accumIn,
  input wire [15:0] mulSrc,
  input wire [15:0] flagsIn,
  input wire [15:0] accumOut,
  input wire [15:0] dataOut,
  input wire dataWrite,
  input wire [15:0] flagsOut,
  input wire [15:0] srcIndexOut,
  input wire [15:0] dstIndexOut,
  // Memory side
  input wire rdReq,
  input wire [15:0] rdAddr,
  input wire wrReq,
  input wire [15:0] wrAddr,
  input wire [15:0] wrData,
  input wire wrWord,
  input wire wrAck
);
  wire [31:0] prod = wordOp ? accumIn * mulSrc : accumIn[7:0] * mulSrc[7:0];
  reg [31:0] prod_q;
  reg hi_q;
  reg word_q;
  reg [15:0] flg_q;
  reg [15:0] delta_q;
  always @(posedge ref_clk) begin
    if (clkEn && !busy && (startMul || startCopy)) begin
      prod_q <= prod;
      hi_q <= wordOp ? |prod[31:16] : |prod[15:8];
      word_q <= wordOp;
      flg_q <= flagsIn;
      delta_q <= flagsIn[10] ? (wordOp ? 16'hFFFE : 16'hFFFF) : (wordOp ? 16'h0002 : 16'h0001);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_mul; clkEn && !busy && startMul; endsequence
  property p_mul_byte; s_mul ##0 !wordOp |=> done && !dataWrite && accumOut == prod_q[15:0]; endproperty
  property p_mul_word; s_mul ##0 wordOp |=> done && dataWrite && {dataOut, accumOut} == prod_q; endproperty
  property p_mul_flags; s_mul |=> flagsOut[0] == hi_q && flagsOut[11] == hi_q && flagsOut[10:8] == flg_q[10:8]; endproperty
  property p_copy_flags; done && $past(busy) |-> flagsOut == flg_q; endproperty
  property p_src_step; rdReq |=> srcIndexOut == $past(rdAddr) + delta_q; endproperty
  property p_dst_step; $rose(wrReq) |-> dstIndexOut == wrAddr + delta_q; endproperty
  property p_wr_size; wrReq |-> wrWord == word_q && (word_q || wrData[15:8] == 8'h00); endproperty
  property p_wr_hold; wrReq && !wrAck |=> wrReq && $stable(wrAddr) && $stable(wrData); endproperty
  a_mul_byte: assert property (p_mul_byte) else $error("byte product wrong");
  a_mul_word: assert property (p_mul_word) else $error("word product wrong");
  a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");
  a_copy_flags: assert property (p_copy_flags) else $error("copy altered flags");
  a_src_step: assert property (p_src_step) else $error("source index step wrong");
  a_dst_step: assert property (p_dst_step) else $error("destination index step wrong");
  a_wr_size: assert property (p_wr_size) else $error("write size wrong");
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped early");
endmodule
bind string_mul_unit string_mul_unit_properties u_chk (.*);

// ### tb/mem_model.sv
`timescale 1ns/10ps
// ==========
// Byte memory answering reads and writes
module mem_model (
  // Clock and pacing
  input wire ref_clk,
  input wire slow,
  // Read port
  input wire rdReq,
  input wire [15:0] rdAddr,
  output reg rdValid,
  output reg [15:0] rdData,
  // Write port
  input wire wrReq,
  input wire [15:0] wrAddr,
  input wire [15:0] wrData,
  input wire wrWord,
  output reg wrAck
);
  reg [7:0] mem [0:255];
  reg [15:0] pend [$];
  reg [2:0] wait_q;
  integer i;
  initial begin
    rdValid = 1'b0;
    wrAck = 1'b0;
    rdData = 16'hA5A5;
    wait_q = 3'h0;
    for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
  end
  always @(posedge ref_clk) begin
    rdValid <= 1'b0;
    wrAck <= 1'b0;
    rdData <= ~rdData;
    wait_q <= (wait_q == 3'h0) ? (slow ? 3'h3 : 3'h0) : wait_q - 3'h1;
    if (rdReq) pend.push_back(rdAddr);
    if (wait_q == 3'h0 && pend.size() > 0 && !rdValid) begin
      rdValid <= 1'b1;
      rdData <= {mem[pend[0][7:0] + 8'h01], mem[pend[0][7:0]]};
      pend.pop_front();
    end
    if (wrReq && !wrAck && wait_q == 3'h0) begin
      wrAck <= 1'b1;
      mem[wrAddr[7:0]] <= wrData[7:0];
      if (wrWord) mem[wrAddr[7:0] + 8'h01] <= wrData[15:8];
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg ref_clk = 0, rst = 1, clkEn = 1, startCopy = 0, startMul = 0, wordOp = 0, repeatPrefix = 0, slow = 0;
  reg [15:0] countIn = 0, srcIndexIn = 0, dstIndexIn = 0, accumIn = 0, mulSrc = 0, flagsIn = 0;
  wire busy, done, dataWrite, rdReq, rdValid, wrReq, wrWord, wrAck;
  wire [15:0] srcIndexOut, dstIndexOut, countOut, accumOut, dataOut, flagsOut, rdAddr, rdData, wrAddr, wrData;
  integer num_errors = 0, check_count = 0, cycles = 0;
  string_mul_unit i_string_mul_unit (.*);
  mem_model u_mem (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  // ==========
  // Shared tasks
  task finish_test;
    begin
      if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task do_mul(input w, input [15:0] a, input [15:0] s, input [15:0] f);
    reg [31:0] e;
    reg c;
    begin
      e = w ? a * s : a[7:0] * s[7:0];
      c = w ? |e[31:16] : |e[15:8];
      @(posedge ref_clk);
      {startMul, wordOp, accumIn, mulSrc, flagsIn} <= {1'b1, w, a, s, f};
      @(posedge ref_clk);
      startMul <= 1'b0;
      #1;
      chk({done, dataWrite, accumOut}, {1'b1, w, e[15:0]});
      if (w) chk(dataOut, e[31:16]);
      chk({flagsOut[11:8], flagsOut[0]}, {c, f[10:8], c});
    end
  endtask
  task do_copy(input w, input repeat_prefix, input d, input slw, input [15:0] n, input [15:0] s, input [15:0] t);
    reg [15:0] delta, k, f, es, et;
    reg [7:0] as, ad;
    integer i, b;
    begin
      delta = d ? (w ? 16'hFFFE : 16'hFFFF) : (w ? 16'h0002 : 16'h0001);
      k = repeat_prefix ? n : 16'h0001;
      f = {4'h0, 1'b1, d, 10'h2D5};
      es = s + k * delta;
      et = t + k * delta;
      @(posedge ref_clk);
      {startCopy, wordOp, repeatPrefix, countIn, srcIndexIn, dstIndexIn, flagsIn, slow} <= {1'b1, w, repeat_prefix, n, s, t, f, slw};
      @(posedge ref_clk);
      startCopy <= 1'b0;
      #1;
      while (done !== 1'b1) begin
        @(posedge ref_clk);
        #1;
      end
      chk(flagsOut, f);
      chk({srcIndexOut, dstIndexOut}, {es, et});
      chk({busy, countOut}, 17'h00000);
      if (k == 0) chk(u_mem.mem[t[7:0]], t[7:0] ^ 8'h5A);
      for (i = 0; i < k; i = i + 1) begin
        for (b = 0; b <= w; b = b + 1) begin
          as = s + i * delta + b;
          ad = t + i * delta + b;
          chk(u_mem.mem[ad], as ^ 8'h5A);
        end
      end
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    do_mul(0, 16'hAB12, 16'hCD05, 16'h0FFF);
    do_mul(0, 16'h00FF, 16'h00FF, 16'h0000);
    do_mul(1, 16'hFFFF, 16'hFFFF, 16'h0000);
    do_mul(1, 16'h1234, 16'h0002, 16'h0FFF);
    do_copy(0, 0, 0, 0, 16'h0005, 16'h0010, 16'h0080);
    do_copy(1, 1, 1, 1, 16'h0003, 16'h003E, 16'h00BE);
    do_copy(0, 1, 0, 0, 16'h0006, 16'h0020, 16'h0060);
    do_copy(1, 1, 0, 0, 16'h0000, 16'h0028, 16'h00D0);
    finish_test;
  end
endmodule
